// ===== telegram_pkg.sv
// constants for the measurement telegram port
package telegram_pkg;
  localparam int TG_BYTES   = 16;
  localparam int HDR_BYTES  = 4;
  localparam int USER_BYTES = 12;
  localparam int TG_W       = TG_BYTES * 8;
  localparam int PHASES     = 3;
  // telegram type, header byte 0 bits 6..4
  localparam logic [2:0] TYPE_ZERO_FRAME = 3'h0;
  localparam logic [2:0] TYPE_READ_VALUE = 3'h1;
  localparam logic [2:0] TYPE_READ_FRAME = 3'h2;
  localparam logic [2:0] TYPE_SET_FRAME  = 3'h3;
  localparam logic [2:0] TYPE_COMMAND    = 3'h4;
  localparam logic [2:0] TYPE_READ_PARAM = 3'h6;
  // communication status codes
  localparam logic [3:0] ERR_OK        = 4'h0;
  localparam logic [3:0] ERR_REFRESH   = 4'h1;
  localparam logic [3:0] ERR_TAG       = 4'h2;
  localparam logic [3:0] ERR_LENGTH    = 4'h3;
  localparam logic [3:0] ERR_NO_FRAME  = 4'h5;
  localparam logic [3:0] ERR_MEASURAND = 4'h6;
  localparam logic [3:0] ERR_COMMAND   = 4'h7;
  localparam logic [3:0] ERR_SET_FRAME = 4'h8;
  localparam logic [3:0] ERR_TYPE      = 4'h9;
  localparam logic [7:0] CMD_ACK_STATUS = 8'h04;
  // measurand identifiers
  localparam logic [7:0] ID_MIN         = 8'h01;
  localparam logic [7:0] ID_MAX         = 8'h29;
  localparam logic [7:0] ID_STATUS      = 8'h29;
  localparam logic [7:0] ID_TOTAL_POWER = 8'h03;
  localparam logic [7:0] ID_VOLT_L1     = 8'h12;
  localparam logic [7:0] ID_PHASE_STEP  = 8'h08;
  localparam logic [7:0] ID_CURR_OFS    = 8'h01;
  localparam logic [7:0] ID_PF_OFS      = 8'h02;
  localparam logic [3:0] TAG_MIN        = 4'h1;
  localparam logic [3:0] TAG_MAX        = 4'hf;
  localparam logic [3:0] LEN_USER_MAX   = 4'hc;
  localparam logic [3:0] LEN_VALUE      = 4'h4;
  localparam logic [3:0] LEN_NONE       = 4'h0;
  // limit violation status word, byte 0 in bits 7..0
  localparam int ST_UV_L2 = 0;
  localparam int ST_UV_L3 = 1;
  localparam int ST_OV_L1 = 2;
  localparam int ST_OT    = 5;
  localparam int ST_UF    = 6;
  localparam int ST_OF    = 7;
  localparam int ST_RESET = 8;
  localparam int ST_OC_L1 = 9;
  localparam int ST_PF_L1 = 12;
  localparam int ST_UV_L1 = 15;
  localparam int ST_W     = 16;
  localparam logic [ST_W-1:0] STATUS_RESET = 16'h0100;
  localparam logic signed [31:0] TOTAL_POWER_MAX_MW = 32'sd3750000;
  // common status bits
  localparam int CS_OF = 0;
  localparam int CS_UF = 1;
  localparam int CS_OT = 2;
  localparam int CS_OV = 3;
  localparam int CS_UV = 4;
  localparam int CS_PF = 5;
  localparam int CS_OC = 6;
endpackage

// ===== energy_meter_telegram_port.sv
// telegram request/response handler with limit status word
//
// Overview of operation
// - telegrams are 16 bytes, 4 header
// - status code in header byte 0 low nibble
// - type in byte 0 bits 6..4, echoed
// - header byte 0 bit 7 always zero
// - byte 1 selects measurand, 1 to 41
// - byte 2 low nibble is dataset tag
// - byte 2 high nibble is user length
// - header byte 3 carries common status
// - failed request: no data, length zero
// - request in, answer later in input area
// - one measurement kept under one tag
// - status word refreshed when tag advances
// - status bits stick until acknowledged
// - acknowledge also clears limit indicators
// - status word sent big endian
// - status byte 0 voltage, temp, frequency
// - status byte 1 current, pf, L1 undervoltage
// - reset flag set on reset, cmd 0x04 clears
// - total power saturates at +/-3750000 mW
// - thresholds come from parameter inputs
// - highest error code wins
// - type codes zero, value, frame, cmd, param
// - common status summarises violation classes
`timescale 1ns/1ps
module energy_meter_telegram_port
  import telegram_pkg::*;
#(
  parameter int VAL_W = 32
)(
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic [TG_W-1:0]              req_image,
  input  wire logic                         req_strobe,
  input  wire logic                         meas_valid,
  input  wire logic [PHASES-1:0][VAL_W-1:0] phase_voltage,
  input  wire logic [PHASES-1:0][VAL_W-1:0] phase_current,
  input  wire logic [PHASES-1:0][VAL_W-1:0] phase_power_factor,
  input  wire logic [VAL_W-1:0]             temperature,
  input  wire logic [VAL_W-1:0]             frequency,
  input  wire logic [31:0]                  total_power_mw,
  input  wire logic [VAL_W-1:0]             voltage_low_limit,
  input  wire logic [VAL_W-1:0]             voltage_high_limit,
  input  wire logic [VAL_W-1:0]             current_high_limit,
  input  wire logic [VAL_W-1:0]             power_factor_low_limit,
  input  wire logic [VAL_W-1:0]             temperature_high_limit,
  input  wire logic [VAL_W-1:0]             frequency_low_limit,
  input  wire logic [VAL_W-1:0]             frequency_high_limit,
  output logic      [TG_W-1:0]              resp_image,
  output logic                              resp_valid,
  output logic      [3:0]                   dataset_tag,
  output logic      [ST_W-1:0]              limit_indicator
);

  if (VAL_W < 8 || VAL_W > 32)
  begin : g_check
    $error("VAL_W must lie between 8 and 32");
  end

  // byte n of a telegram image, B0 in the top bits
  function automatic logic [7:0] tg_byte(
    input logic [TG_W-1:0] img,
    input int              n
  );
    tg_byte = img[TG_W-1-8*n -: 8];
  endfunction

  function automatic logic [3:0] raise(
    input logic [3:0] cur,
    input logic [3:0] code
  );
    raise = (code > cur) ? code : cur;
  endfunction

  // measurement snapshot state
  logic [3:0]                   tag_q, tag_d;
  logic [PHASES-1:0][VAL_W-1:0] volt_q, volt_d;
  logic [PHASES-1:0][VAL_W-1:0] curr_q, curr_d;
  logic [PHASES-1:0][VAL_W-1:0] pf_q, pf_d;
  logic [31:0]                  power_q, power_d;
  logic [ST_W-1:0]              status_q, status_d;
  logic [ST_W-1:0]              viol;
  logic [ST_W-1:0]              ack_clear;
  logic [31:0]                  power_sat;

  // response state
  logic [TG_W-1:0] resp_q, resp_d;
  logic            valid_q, valid_d;

  // per-phase limit comparisons against parameter inputs
  for (genvar p = 0; p < PHASES; p++)
  begin : g_phase
    assign viol[ST_OV_L1+p] =
      phase_voltage[p] > voltage_high_limit;
    assign viol[ST_OC_L1+p] =
      phase_current[p] > current_high_limit;
    assign viol[ST_PF_L1+p] =
      $signed(phase_power_factor[p]) <
      $signed(power_factor_low_limit);
  end

  assign viol[ST_UV_L2] =
    phase_voltage[1] < voltage_low_limit;
  assign viol[ST_UV_L3] =
    phase_voltage[2] < voltage_low_limit;
  assign viol[ST_UV_L1] =
    phase_voltage[0] < voltage_low_limit;
  assign viol[ST_OT] =
    temperature > temperature_high_limit;
  assign viol[ST_UF] = frequency < frequency_low_limit;
  assign viol[ST_OF] = frequency > frequency_high_limit;
  // reset flag is never raised by a measurement
  assign viol[ST_RESET] = 1'b0;

  // out of range power is clipped, not wrapped
  always_comb
  begin
    if ($signed(total_power_mw) > TOTAL_POWER_MAX_MW)
      power_sat = TOTAL_POWER_MAX_MW;
    else if ($signed(total_power_mw) < -TOTAL_POWER_MAX_MW)
      power_sat = -TOTAL_POWER_MAX_MW;
    else
      power_sat = total_power_mw;
  end

  // common status summary of a status word
  function automatic logic [7:0] common_of(
    input logic [ST_W-1:0] s
  );
    logic [7:0] c;
    c        = 8'h00;
    c[CS_OF] = s[ST_OF];
    c[CS_UF] = s[ST_UF];
    c[CS_OT] = s[ST_OT];
    c[CS_OV] = |s[ST_OV_L1 +: PHASES];
    c[CS_UV] = s[ST_UV_L1] | s[ST_UV_L2] | s[ST_UV_L3];
    c[CS_PF] = |s[ST_PF_L1 +: PHASES];
    c[CS_OC] = |s[ST_OC_L1 +: PHASES];
    common_of = c;
  endfunction

  // request decode
  logic [7:0]  rq_b0, rq_id, rq_b2, rq_cmd;
  logic [2:0]  rq_type;
  logic [3:0]  rq_tag, rq_len, err;
  logic [31:0] value;
  logic        found;
  logic        ack_ok;

  always_comb
  begin
    rq_b0   = tg_byte(req_image, 0);
    rq_id   = tg_byte(req_image, 1);
    rq_b2   = tg_byte(req_image, 2);
    rq_cmd  = tg_byte(req_image, HDR_BYTES);
    rq_type = rq_b0[6:4];
    rq_tag  = rq_b2[3:0];
    rq_len  = rq_b2[7:4];
    value   = 32'h0;
    found   = 1'b0;
    err     = ERR_OK;
    ack_ok  = 1'b0;
    for (int p = 0; p < PHASES; p++)
    begin
      if (rq_id == ID_VOLT_L1 + ID_PHASE_STEP * 8'(p))
      begin
        value = 32'(volt_q[p]);
        found = 1'b1;
      end
      if (rq_id == ID_VOLT_L1 + ID_PHASE_STEP * 8'(p) + ID_CURR_OFS)
      begin
        value = 32'(curr_q[p]);
        found = 1'b1;
      end
      if (rq_id == ID_VOLT_L1 + ID_PHASE_STEP * 8'(p) + ID_PF_OFS)
      begin
        value = 32'(pf_q[p]);
        found = 1'b1;
      end
    end
    if (rq_id == ID_TOTAL_POWER)
    begin
      value = power_q;
      found = 1'b1;
    end
    if (rq_id == ID_STATUS)
    begin
      value = 32'(status_q);
      found = 1'b1;
    end
    if (rq_b0[7])
      err = raise(err, ERR_TYPE);
    if (rq_len > LEN_USER_MAX)
      err = raise(err, ERR_LENGTH);
    case (rq_type)
      TYPE_READ_VALUE:
      begin
        if (rq_id < ID_MIN || rq_id > ID_MAX || !found)
          err = raise(err, ERR_MEASURAND);
        if (rq_tag < TAG_MIN || rq_tag != tag_q)
          err = raise(err, ERR_TAG);
        if (tag_q == 4'h0)
          err = raise(err, ERR_REFRESH);
      end
      TYPE_COMMAND:
      begin
        if (rq_cmd != CMD_ACK_STATUS)
          err = raise(err, ERR_COMMAND);
      end
      TYPE_ZERO_FRAME, TYPE_READ_FRAME:
        err = raise(err, ERR_NO_FRAME);
      TYPE_SET_FRAME:
        err = raise(err, ERR_SET_FRAME);
      TYPE_READ_PARAM:
        err = raise(err, ERR_TYPE);
      default:
        err = raise(err, ERR_TYPE);
    endcase
    ack_ok = req_strobe && rq_type == TYPE_COMMAND &&
             err == ERR_OK;
  end

  assign ack_clear = ack_ok ? {ST_W{1'b1}} : {ST_W{1'b0}};

  // measurement group next state
  always_comb
  begin
    tag_d   = tag_q;
    volt_d  = volt_q;
    curr_d  = curr_q;
    pf_d    = pf_q;
    power_d = power_q;
    // acknowledge clears, a same-cycle violation still sets
    status_d = status_q & ~ack_clear;
    if (meas_valid)
    begin
      // all values of one measurement share the new tag
      tag_d   = (tag_q == TAG_MAX) ? TAG_MIN : tag_q + 4'h1;
      volt_d  = phase_voltage;
      curr_d  = phase_current;
      pf_d    = phase_power_factor;
      power_d = power_sat;
      status_d = status_d | viol;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tag_q    <= 4'h0;
      volt_q   <= '0;
      curr_q   <= '0;
      pf_q     <= '0;
      power_q  <= 32'h0;
      status_q <= STATUS_RESET;
    end
    else
    begin
      tag_q    <= tag_d;
      volt_q   <= volt_d;
      curr_q   <= curr_d;
      pf_q     <= pf_d;
      power_q  <= power_d;
      status_q <= status_d;
    end
  end

  // response group next state
  always_comb
  begin
    resp_d  = resp_q;
    valid_d = 1'b0;
    if (req_strobe)
    begin
      valid_d = 1'b1;
      resp_d  = '0;
      resp_d[TG_W-1 -: 8]  = {1'b0, rq_type, err};
      resp_d[TG_W-9 -: 8]  = rq_id;
      resp_d[TG_W-17 -: 8] = {LEN_NONE, tag_q};
      resp_d[TG_W-25 -: 8] = common_of(status_d);
      if (err == ERR_OK && rq_type == TYPE_READ_VALUE)
      begin
        resp_d[TG_W-17 -: 8] = {LEN_VALUE, tag_q};
        // most significant byte goes out first
        resp_d[TG_W-33 -: 32] = value;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      resp_q  <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      resp_q  <= resp_d;
      valid_q <= valid_d;
    end
  end

  assign resp_image      = resp_q;
  assign resp_valid      = valid_q;
  assign dataset_tag     = tag_q;
  // indicators follow the sticky word, so acks darken them
  assign limit_indicator = status_q;

endmodule // energy_meter_telegram_port

// ===== emtp_chk.sv
// checker on the telegram port pins
`timescale 1ns/1ps
module emtp_chk
  import telegram_pkg::*;
(
  input wire logic            clk,
  input wire logic            rstn,
  input wire logic [TG_W-1:0] req_image,
  input wire logic            req_strobe,
  input wire logic            meas_valid,
  input wire logic [TG_W-1:0] resp_image,
  input wire logic            resp_valid,
  input wire logic [3:0]      dataset_tag,
  input wire logic [ST_W-1:0] limit_indicator
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  wire [ST_W-1:0] w = limit_indicator;
  wire [7:0]      cs = {1'b0, |w[11:9], |w[14:12], w[0] | w[1] | w[15],
                        |w[4:2], w[5], w[6], w[7]};
  // header faults would turn an acknowledge into an error answer
  wire ack = req_strobe && req_image[127:124] == {1'b0, TYPE_COMMAND} &&
             req_image[111:108] <= LEN_USER_MAX &&
             req_image[95:88] == CMD_ACK_STATUS;
  sequence s_req;
    req_strobe;
  endsequence
  sequence s_ans;
    ##1 resp_valid;
  endsequence
  a_answer_next: assert property (s_req |-> s_ans)
    else $error("no answer");
  // the status nibble between type and id is the answer's own
  a_hdr_echo: assert property (s_req |=>
    resp_image[126:124] == $past(req_image[126:124]) &&
    resp_image[119:112] == $past(req_image[119:112]))
    else $error("no echo");
  a_fix_bit7: assert property (resp_valid |-> !resp_image[127])
    else $error("bit 7 set");
  a_err_empty: assert property (resp_valid && resp_image[123:120] != 0
    |-> resp_image[111:108] == 0 && resp_image[95:0] == '0)
    else $error("error with data");
  a_common_sum: assert property (resp_valid |->
    resp_image[103:96] == cs)
    else $error("common status");
  a_tag_step: assert property (meas_valid |=> dataset_tag ==
    ($past(dataset_tag) == 4'hf ? 4'h1 : $past(dataset_tag) + 4'h1))
    else $error("tag step");
  a_only_meas: assert property (!ack && !meas_valid |=> $stable(w))
    else $error("word moved");
  a_sticky: assert property (!ack |=> (w & $past(w)) == $past(w))
    else $error("bit dropped");
  a_ack_clear: assert property (ack && !meas_valid |=> w == '0)
    else $error("ack kept bits");
endmodule // emtp_chk

bind energy_meter_telegram_port emtp_chk i_chk (.clk, .rstn, .req_image,
  .req_strobe, .meas_valid, .resp_image, .resp_valid, .dataset_tag,
  .limit_indicator);

// ===== head_model.sv
// head module model writing request telegrams
`timescale 1ns/1ps
module head_model
  import telegram_pkg::*;
(
  input  wire logic            clk,
  output logic      [TG_W-1:0] req_image,
  output logic                 req_strobe
);
  initial
  begin
    req_image = '0;
    req_strobe = 1'b0;
  end
  task automatic send(input logic [TG_W-1:0] img);
    @(posedge clk);
    #1;
    req_image = img;
    req_strobe = 1'b1;
    @(posedge clk);
    #1;
    req_strobe = 1'b0;
    // area not held after the pulse: stale bytes must not be reused
    req_image = ~img;
  endtask
endmodule // head_model

// ===== energy_meter_telegram_port_tb_top.sv
// bench: head model requests, answers checked from a queue
`timescale 1ns/1ps
module energy_meter_telegram_port_tb_top
  import telegram_pkg::*;
;
  logic                    clk, rstn, meas_valid, req_strobe, resp_valid;
  logic [PHASES-1:0][31:0] volt, curr, pf;
  logic [31:0]             temp, freq, tpow, vlo, vhi, ihi, pflo, thi;
  logic [31:0]             flo, fhi;
  logic [TG_W-1:0]         req_image, resp_image, expv[$], expm[$];
  logic [3:0]              tag, dataset_tag;
  logic [15:0]             word, limit_indicator;
  logic [31:0]             errs[12] = '{32'h90290009, 32'h1029d003,
    32'h10000006, 32'h102a0006, 32'h10290102, 32'h00290005, 32'h20290005,
    32'h30290008, 32'h60290009, 32'h50290009, 32'h70290009, 32'h1000d006};
  int                      fails, num_checks;

  head_model i_head (.clk, .req_image, .req_strobe);
  energy_meter_telegram_port i_dut (.clk, .rstn, .req_image, .req_strobe,
    .meas_valid, .phase_voltage(volt), .phase_current(curr),
    .phase_power_factor(pf), .temperature(temp), .frequency(freq),
    .total_power_mw(tpow), .voltage_low_limit(vlo),
    .voltage_high_limit(vhi), .current_high_limit(ihi),
    .power_factor_low_limit(pflo), .temperature_high_limit(thi),
    .frequency_low_limit(flo), .frequency_high_limit(fhi), .resp_image,
    .resp_valid, .dataset_tag, .limit_indicator);

  function automatic logic [7:0] cs(input logic [15:0] w);
    return {1'b0, |w[11:9], |w[14:12], w[0] | w[1] | w[15], |w[4:2],
            w[5], w[6], w[7]};
  endfunction
  function automatic logic [31:0] sat(input logic signed [31:0] v);
    return v > TOTAL_POWER_MAX_MW ? TOTAL_POWER_MAX_MW :
           v < -TOTAL_POWER_MAX_MW ? -TOTAL_POWER_MAX_MW : v;
  endfunction
  task automatic chk(input logic [TG_W-1:0] got, e, m);
    num_checks++;
    if ((got & m) !== (e & m))
    begin
      fails++;
      $display("wrong value at %0t: answer %h", $time, got);
    end
  endtask
  task automatic req(input logic [TG_W-1:0] img, e, m);
    expv.push_back(e);
    expm.push_back(m);
    i_head.send(img);
  endtask
  // bytes past the 4-byte value are left open for a good read
  task automatic rd(input logic [7:0] id, input logic [31:0] v);
    req({8'h10, id, 4'h0, tag, 104'h0},
        {8'h10, id, 4'h4, tag, cs(word), v, 64'h0}, {{64{1'b1}}, 64'h0});
  endtask
  task automatic meas;
    @(posedge clk);
    #1;
    {vlo, vhi, ihi} = {$urandom_range(1, 6), $urandom_range(9, 14),
                       $urandom_range(6, 12)};
    {thi, flo, fhi} = {$urandom_range(6, 12), $urandom_range(2, 7),
                       $urandom_range(8, 13)};
    {temp, freq} = {$urandom_range(0, 15), $urandom_range(0, 15)};
    pflo = $urandom_range(0, 4) - 2;
    tpow = $urandom_range(3740000, 3760000);
    if ($urandom_range(0, 1))
      tpow = -tpow;
    for (int p = 0; p < PHASES; p++)
    begin
      {volt[p], curr[p]} = {$urandom_range(0, 15), $urandom_range(0, 15)};
      pf[p] = $urandom_range(0, 15) - 8;
      word[2 + p] |= volt[p] > vhi;
      word[9 + p] |= curr[p] > ihi;
      word[12 + p] |= $signed(pf[p]) < $signed(pflo);
    end
    word[15] |= volt[0] < vlo;
    word[1:0] |= {volt[2] < vlo, volt[1] < vlo};
    word[7:5] |= {freq > fhi, freq < flo, temp > thi};
    meas_valid = 1'b1;
    @(posedge clk);
    #1 meas_valid = 1'b0;
    tag = tag == 4'hf ? 4'h1 : tag + 4'h1;
    chk(128'({dataset_tag, limit_indicator}), 128'({tag, word}), '1);
  endtask
  task automatic reset_dut;
    #1 rstn = 1'b0;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    word = STATUS_RESET;
    tag = 4'h0;
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk)
    if (resp_valid === 1'b1)
    begin
      if (expv.size() == 0)
        chk('0, '1, '1);
      else
        chk(resp_image, expv.pop_front(), expm.pop_front());
    end
  initial
  begin
    #400000;
    fails++;
    test_done;
  end
  initial
  begin
    {rstn, meas_valid, fails, num_checks} = '0;
    {volt, curr, pf, temp, freq, tpow} = '0;
    {vlo, vhi, ihi, pflo, thi, flo, fhi} = '0;
    void'($urandom(32'he186));
    reset_dut;
    req({8'h10, 8'h29, 112'h0}, {8'h12, 8'h29, 112'h0}, '1);
    for (int i = 0; i < 16; i++)
    begin
      meas;
      rd(ID_STATUS, {16'h0, word});
      rd(ID_TOTAL_POWER, sat(tpow));
      rd(8'd18 + 8'(i % 3 * 8), volt[i % 3]);
      rd(8'd19 + 8'(i % 3 * 8), curr[i % 3]);
      rd(8'd20 + 8'(i % 3 * 8), pf[i % 3]);
    end
    for (int j = 0; j < 12; j++)
      req({errs[j][31:12], tag + errs[j][11:8], 104'h0}, {1'b0,
        errs[j][30:28], errs[j][3:0], errs[j][23:16], 4'h0, tag, cs(word),
        96'h0}, '1);
    req({32'h40001000, 8'h05, 88'h0},
        {8'h47, 8'h0, 4'h0, tag, cs(word), 96'h0}, '1);
    word = 16'h0;
    req({32'h40001000, 8'h04, 88'h0},
        {8'h40, 8'h0, 4'h0, tag, 8'h0, 96'h0}, '1);
    rd(ID_STATUS, 32'h0);
    repeat (3) @(posedge clk);
    reset_dut;
    meas;
    rd(ID_STATUS, {16'h0, word});
    repeat (4) @(posedge clk);
    if (expv.size() != 0)
      chk('0, '1, '1);
    test_done;
  end
endmodule // energy_meter_telegram_port_tb_top
